//--- src/slcd_regs.svh
// Purpose: Register map, field positions, reset values and timing counts of the segment LCD frame timing block.
// Assumes: 32-bit APB words; each register index maps to byte address four times the index.
// Notes: Definitions only.
`ifndef SLCD_REGS_SVH
`define SLCD_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define SLCD_IDX_CTRL_A 12'h0e4
`define SLCD_IDX_DUTY_BIAS 12'h0e5
`define SLCD_IDX_FRAME_RATE 12'h0e6
`define SLCD_ADDR_CTRL_A 12'h390
`define SLCD_ADDR_DUTY_BIAS 12'h394
`define SLCD_ADDR_FRAME_RATE 12'h398

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define SLCD_A_ENABLE 7
`define SLCD_A_FLAG 4
`define SLCD_A_BUF_DIS 2
`define SLCD_A_SUPPLY_DIS 1
`define SLCD_A_BLANK 0
`define SLCD_A_WMASK 8'h87
`define SLCD_B_CLK_SEL 7
`define SLCD_B_HALF_BIAS 6
`define SLCD_B_DUTY_HI 5
`define SLCD_B_DUTY_LO 4
`define SLCD_B_WMASK 8'hf7
`define SLCD_F_PS_HI 6
`define SLCD_F_PS_LO 4
`define SLCD_F_CD_HI 2
`define SLCD_F_CD_LO 0
`define SLCD_F_WMASK 8'h77

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define SLCD_RST_A 8'h00
`define SLCD_RST_B 8'h00
`define SLCD_RST_F 8'h00
`define SLCD_K_DEFAULT 4'h8
`define SLCD_K_THIRD 4'h6
`define SLCD_SEG_MIN 5'h0d
`define SLCD_SEG_CODE6 5'h18
`define SLCD_SEG_CODE7 5'h19
`define SLCD_NUM_SEG 25

`endif

//--- src/slcd_pkg.sv
// Purpose: Types shared by the segment LCD frame timing modules.
// Assumes: Nothing beyond the register header.
// Notes: Constants live in slcd_regs.svh.
package slcd_pkg;
  typedef enum logic [1:0] {
    SLCD_DUTY_STATIC = 2'b00,
    SLCD_DUTY_HALF = 2'b01,
    SLCD_DUTY_THIRD = 2'b10,
    SLCD_DUTY_QUARTER = 2'b11
  } slcd_duty_t;
endpackage

//--- src/slcd_timing_if.sv
// Purpose: Carries clock chain settings and timing strobes between the frame timing modules.
// Assumes: Single clock domain, all strobes are one-cycle enables.
// Notes: None.
`timescale 1ns/1ns
interface slcd_timing_if;
  logic run;
  logic src_tick;
  logic [2:0] ps_sel;
  logic [2:0] cd_sel;
  slcd_pkg::slcd_duty_t duty;
  logic lcd_tick;
  logic frame_start;
  logic [1:0] common_idx;
  modport ctrl (output run, output src_tick, output ps_sel, output cd_sel, output duty,
                input lcd_tick, input frame_start, input common_idx);
  modport clkgen (input run, input src_tick, input ps_sel, input cd_sel, output lcd_tick);
  modport seq (input run, input duty, input lcd_tick, output frame_start, output common_idx);
endinterface // slcd_timing_if

//--- src/slcd_clock_chain.sv
// Purpose: Prescaler tap and 1..8 divider that make the prescaled LCD clock enable.
// Assumes: src_tick marks one period of the selected source clock.
// Notes: Counters clear while the block is off so every start is aligned.
`timescale 1ns/1ns
`include "slcd_regs.svh"
module slcd_clock_chain (
  input wire logic pclk,
  input wire logic presetn,
  slcd_timing_if.clkgen tif
);
  logic [11:0] pre_reg;
  logic [11:0] pre_next;
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic tick_reg;
  logic tick_next;
  logic [11:0] tap_last;
  logic tap_hit;

  always_comb begin
    unique case (tif.ps_sel)
      3'h0: tap_last = 12'h00f;
      3'h1: tap_last = 12'h03f;
      3'h2: tap_last = 12'h07f;
      3'h3: tap_last = 12'h0ff;
      3'h4: tap_last = 12'h1ff;
      3'h5: tap_last = 12'h3ff;
      3'h6: tap_last = 12'h7ff;
      3'h7: tap_last = 12'hfff;
    endcase
    tap_hit = tif.src_tick && (pre_reg >= tap_last);
    pre_next = pre_reg;
    div_next = div_reg;
    tick_next = 1'b0;
    if (!tif.run) begin
      pre_next = 12'h000;
      div_next = 3'h0;
    end else if (tif.src_tick) begin
      pre_next = tap_hit ? 12'h000 : pre_reg + 12'h001;
      if (tap_hit) begin
        // A code change mid-count never strands the divider above its new limit.
        if (div_reg >= tif.cd_sel) begin
          div_next = 3'h0;
          tick_next = 1'b1;
        end else begin
          div_next = div_reg + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 12'h000;
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tif.lcd_tick = tick_reg;
endmodule // slcd_clock_chain

//--- src/slcd_phase_seq.sv
// Purpose: Steps the common phases and marks the start of every frame.
// Assumes: lcd_tick is the prescaled LCD clock enable.
// Notes: K ticks make one frame; each common gets K divided by its count.
`timescale 1ns/1ns
`include "slcd_regs.svh"
module slcd_phase_seq (
  input wire logic pclk,
  input wire logic presetn,
  slcd_timing_if.seq tif
);
  logic [3:0] step_reg;
  logic [3:0] step_next;
  logic [1:0] com_reg;
  logic [1:0] com_next;
  logic sof_reg;
  logic sof_next;
  logic [3:0] k_last;
  logic [3:0] per_com_last;
  logic [3:0] sub_reg;
  logic [3:0] sub_next;

  always_comb begin
    k_last = (tif.duty == slcd_pkg::SLCD_DUTY_THIRD) ? `SLCD_K_THIRD - 4'h1 : `SLCD_K_DEFAULT - 4'h1;
    unique case (tif.duty)
      slcd_pkg::SLCD_DUTY_STATIC: per_com_last = 4'h7;
      slcd_pkg::SLCD_DUTY_HALF: per_com_last = 4'h3;
      slcd_pkg::SLCD_DUTY_THIRD: per_com_last = 4'h1;
      slcd_pkg::SLCD_DUTY_QUARTER: per_com_last = 4'h1;
    endcase
    step_next = step_reg;
    sub_next = sub_reg;
    com_next = com_reg;
    sof_next = 1'b0;
    if (!tif.run) begin
      step_next = 4'h0;
      sub_next = 4'h0;
      com_next = 2'h0;
    end else if (tif.lcd_tick) begin
      if (step_reg >= k_last) begin
        step_next = 4'h0;
        sub_next = 4'h0;
        com_next = 2'h0;
        sof_next = 1'b1;
      end else begin
        step_next = step_reg + 4'h1;
        if (sub_reg >= per_com_last) begin
          sub_next = 4'h0;
          com_next = com_reg + 2'h1;
        end else begin
          sub_next = sub_reg + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= 4'h0;
      sub_reg <= 4'h0;
      com_reg <= 2'h0;
      sof_reg <= 1'b0;
    end else begin
      step_reg <= step_next;
      sub_reg <= sub_next;
      com_reg <= com_next;
      sof_reg <= sof_next;
    end
  end

  assign tif.frame_start = sof_reg;
  assign tif.common_idx = com_reg;
endmodule // slcd_phase_seq

//--- src/slcd_frame_timing.sv
// Purpose: APB register file and frame timing control of a segment LCD controller.
// Assumes: pclk at 10 MHz; async_clk_tick is a one-cycle pulse per asynchronous source period.
// Notes: The analog parts are steered by the level outputs of this block.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`include "slcd_regs.svh"
module slcd_frame_timing (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic async_clk_tick,
  output logic lcd_enable,
  output logic bias_buffer_disable,
  output logic internal_supply_disable,
  output logic display_blank,
  output logic lcd_clock_source_sel,
  output logic half_bias_sel,
  output logic static_bias,
  output logic prescaled_lcd_clock,
  output logic start_of_frame,
  output logic [3:0] common_out_active,
  output logic [3:0] common_pin_lcd,
  output logic [24:0] segment_pin_lcd
);
  slcd_timing_if tif ();

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_a_next;
  logic [7:0] duty_bias_reg;
  logic [7:0] duty_bias_next;
  logic [7:0] frame_rate_reg;
  logic [7:0] frame_rate_next;
  logic flag_reg;
  logic flag_next;
  logic blank_reg;
  logic blank_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [3:0] com_act_reg;
  logic [3:0] com_act_next;
  logic [3:0] com_pin_reg;
  logic [3:0] com_pin_next;
  logic [24:0] seg_pin_reg;
  logic [24:0] seg_pin_next;
  logic [6:0] level_reg;
  logic [6:0] level_next;
  logic acc;
  logic wr_fire;
  logic hit_a;
  logic hit_b;
  logic hit_f;
  logic [7:0] rd_byte;
  logic [4:0] seg_count;
  logic running;
  logic hit_any;

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // One wait state lets read data come from a flip-flop, as every output must.
  always_comb begin
    acc = psel && penable;
    hit_a = (paddr == `SLCD_ADDR_CTRL_A);
    hit_b = (paddr == `SLCD_ADDR_DUTY_BIAS);
    hit_f = (paddr == `SLCD_ADDR_FRAME_RATE);
    hit_any = hit_a || hit_b || hit_f;
    // A request dropped before pready is forgotten; only the ready edge commits a write.
    wr_fire = acc && pready_reg && pwrite;
    // Unmapped offsets read as zero and flag an error rather than alias a register.
    rd_byte = 8'h00;
    if (hit_a) begin
      rd_byte = ctrl_a_reg;
      rd_byte[`SLCD_A_FLAG] = flag_reg;
    end else if (hit_b) begin
      rd_byte = duty_bias_reg & `SLCD_B_WMASK;
    end else if (hit_f) begin
      rd_byte = frame_rate_reg & `SLCD_F_WMASK;
    end
    pready_next = acc && !pready_reg;
    pslverr_next = acc && !pready_reg && !hit_any;
    prdata_next = prdata_reg;
    if (acc && !pready_reg) begin
      prdata_next = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  // Reserved bits are dropped on write, so a read-modify-write can never set them.
  always_comb begin
    ctrl_a_next = ctrl_a_reg;
    duty_bias_next = duty_bias_reg;
    frame_rate_next = frame_rate_reg;
    if (wr_fire && hit_a) begin
      ctrl_a_next = pwdata[7:0] & `SLCD_A_WMASK;
    end
    if (wr_fire && hit_b) begin
      duty_bias_next = pwdata[7:0] & `SLCD_B_WMASK;
    end
    if (wr_fire && hit_f) begin
      frame_rate_next = pwdata[7:0] & `SLCD_F_WMASK;
    end
  end

  // --------------------------------------------------------------------------
  // Frame flag and blank latching
  // --------------------------------------------------------------------------
  always_comb begin
    // A frame start in the same cycle as a clearing write keeps the flag set.
    flag_next = flag_reg;
    if (wr_fire && hit_a && pwdata[`SLCD_A_FLAG]) begin
      flag_next = 1'b0;
    end
    if (tif.frame_start) begin
      flag_next = 1'b1;
    end
    blank_next = blank_reg;
    // Switching off drops blanking at once, so a later enable does not start dark.
    if (!running) begin
      blank_next = 1'b0;
    end else if (tif.frame_start) begin
      blank_next = ctrl_a_reg[`SLCD_A_BLANK];
    end
  end

  // --------------------------------------------------------------------------
  // Pin function and drive outputs
  // --------------------------------------------------------------------------
  always_comb begin
    // The chain restarts from zero while the driver is off, so every enable starts a whole frame.
    running = ctrl_a_reg[`SLCD_A_ENABLE];
    tif.run = running;
    // The asynchronous source arrives as one pulse per period, so no second clock is needed.
    if (duty_bias_reg[`SLCD_B_CLK_SEL]) begin
      tif.src_tick = async_clk_tick;
    end else begin
      tif.src_tick = 1'b1;
    end
    tif.ps_sel = frame_rate_reg[`SLCD_F_PS_HI:`SLCD_F_PS_LO];
    tif.cd_sel = frame_rate_reg[`SLCD_F_CD_HI:`SLCD_F_CD_LO];
    tif.duty = slcd_pkg::slcd_duty_t'(duty_bias_reg[`SLCD_B_DUTY_HI:`SLCD_B_DUTY_LO]);
    // The two top codes add one pin each instead of two.
    unique case (duty_bias_reg[2:0])
      3'h6: seg_count = `SLCD_SEG_CODE6;
      3'h7: seg_count = `SLCD_SEG_CODE7;
      default: seg_count = `SLCD_SEG_MIN + {1'b0, duty_bias_reg[2:0], 1'b0};
    endcase
    seg_pin_next = 25'h000_0000;
    for (int i = 0; i < `SLCD_NUM_SEG; i++) begin
      seg_pin_next[i] = running && (5'(i) < seg_count);
    end
    // Commons that the duty leaves unused go back to port function.
    unique case (tif.duty)
      slcd_pkg::SLCD_DUTY_STATIC: com_pin_next = 4'h1;
      slcd_pkg::SLCD_DUTY_HALF: com_pin_next = 4'h3;
      slcd_pkg::SLCD_DUTY_THIRD: com_pin_next = 4'h7;
      slcd_pkg::SLCD_DUTY_QUARTER: com_pin_next = 4'hf;
    endcase
    if (!running) begin
      com_pin_next = 4'h0;
    end
    com_act_next = 4'h0;
    if (running && !blank_next) begin
      com_act_next[tif.common_idx] = 1'b1;
    end
    // Level outputs: enable, buffer off, supply off, blank, clock sel, half bias, static bias.
    level_next[0] = running;
    level_next[1] = ctrl_a_reg[`SLCD_A_BUF_DIS];
    level_next[2] = ctrl_a_reg[`SLCD_A_SUPPLY_DIS];
    level_next[3] = blank_next;
    level_next[4] = duty_bias_reg[`SLCD_B_CLK_SEL];
    // Static duty has no bias choice, so half bias is held low there.
    level_next[5] = (tif.duty != slcd_pkg::SLCD_DUTY_STATIC) && duty_bias_reg[`SLCD_B_HALF_BIAS];
    level_next[6] = (tif.duty == slcd_pkg::SLCD_DUTY_STATIC);
  end

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg <= `SLCD_RST_A;
      duty_bias_reg <= `SLCD_RST_B;
      frame_rate_reg <= `SLCD_RST_F;
      flag_reg <= 1'b0;
      blank_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      com_act_reg <= 4'h0;
      com_pin_reg <= 4'h0;
      seg_pin_reg <= 25'h000_0000;
      level_reg <= 7'h00;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      duty_bias_reg <= duty_bias_next;
      frame_rate_reg <= frame_rate_next;
      flag_reg <= flag_next;
      blank_reg <= blank_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      com_act_reg <= com_act_next;
      com_pin_reg <= com_pin_next;
      seg_pin_reg <= seg_pin_next;
      level_reg <= level_next;
    end
  end

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  slcd_clock_chain u_clock_chain (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif.clkgen)
  );

  slcd_phase_seq u_phase_seq (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif.seq)
  );

  // --------------------------------------------------------------------------
  // Strobe outputs
  // --------------------------------------------------------------------------
  // Both strobes pass one more flip-flop so every port is registered, at one cycle of lag.
  logic lcd_tick_reg;
  logic lcd_tick_next;
  logic sof_out_reg;
  logic sof_out_next;

  always_comb begin
    lcd_tick_next = tif.lcd_tick;
    sof_out_next = tif.frame_start;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcd_tick_reg <= 1'b0;
      sof_out_reg <= 1'b0;
    end else begin
      lcd_tick_reg <= lcd_tick_next;
      sof_out_reg <= sof_out_next;
    end
  end

  // --------------------------------------------------------------------------
  // Port outputs
  // --------------------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign lcd_enable = level_reg[0];
  assign bias_buffer_disable = level_reg[1];
  assign internal_supply_disable = level_reg[2];
  assign display_blank = level_reg[3];
  assign lcd_clock_source_sel = level_reg[4];
  assign half_bias_sel = level_reg[5];
  assign static_bias = level_reg[6];
  assign prescaled_lcd_clock = lcd_tick_reg;
  assign start_of_frame = sof_out_reg;
  assign common_out_active = com_act_reg;
  assign common_pin_lcd = com_pin_reg;
  assign segment_pin_lcd = seg_pin_reg;
endmodule // slcd_frame_timing

//--- testbench/slcd_frame_timing_sva.sv
// Purpose: Port-level assertions for the segment LCD frame timing block.
// Assumes: One pclk domain; the frame rate setting is shadowed from APB writes.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ns
`include "slcd_regs.svh"
module slcd_frame_timing_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic async_clk_tick,
  input wire logic lcd_enable,
  input wire logic display_blank,
  input wire logic lcd_clock_source_sel,
  input wire logic half_bias_sel,
  input wire logic static_bias,
  input wire logic prescaled_lcd_clock,
  input wire logic start_of_frame,
  input wire logic [3:0] common_out_active,
  input wire logic [3:0] common_pin_lcd,
  input wire logic [24:0] segment_pin_lcd
);
  // ----------------
  // Helper counters
  // ----------------
  logic [7:0] fr_reg;
  logic [15:0] src_cnt;
  logic [3:0] tk_cnt;
  logic seen;
  logic wr_fr;
  logic src;
  logic [15:0] exp_nd;
  logic [3:0] exp_k;
  assign wr_fr = psel && penable && pready && pwrite && (paddr == `SLCD_ADDR_FRAME_RATE);
  assign src = lcd_clock_source_sel ? async_clk_tick : 1'b1;
  assign exp_nd = ((fr_reg[6:4] == 3'h0) ? 16'h0010 : (16'h0020 << fr_reg[6:4])) * ({13'h0, fr_reg[2:0]} + 16'h1);
  assign exp_k = (common_pin_lcd == 4'h7) ? 4'h6 : 4'h8;
  // Settings changes restart the period measurement, so only steady periods are judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_reg <= 8'h00;
      src_cnt <= 16'h0000;
      tk_cnt <= 4'h0;
      seen <= 1'b0;
    end else begin
      if (wr_fr) fr_reg <= pwdata[7:0];
      if (wr_fr || !lcd_enable || $changed(lcd_clock_source_sel)) begin
        seen <= 1'b0;
        src_cnt <= 16'h0000;
      end else if (prescaled_lcd_clock) begin
        seen <= 1'b1;
        src_cnt <= {15'h0, src};
      end else src_cnt <= src_cnt + {15'h0, src};
      if (!lcd_enable || start_of_frame) tk_cnt <= 4'h0;
      else if (prescaled_lcd_clock) tk_cnt <= tk_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -----------
  // Assertions
  // -----------
  a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready not after one wait");
  a_reserved_zero: assert property (pready && !pwrite && paddr != `SLCD_ADDR_CTRL_A |-> prdata[31:8] == 24'h0 && !prdata[3]
    && !(paddr == `SLCD_ADDR_FRAME_RATE && prdata[7])) else $error("reserved bit read as one");
  a_src_period: assert property (prescaled_lcd_clock && seen |-> src_cnt == exp_nd) else $error("prescaled clock period");
  a_frame_ticks: assert property (start_of_frame |-> tk_cnt == exp_k) else $error("ticks per frame");
  a_blank_at_frame: assert property ($rose(display_blank) |-> start_of_frame || $past(start_of_frame)
    || $past(start_of_frame, 2)) else $error("blank taken mid frame");
  a_blank_ground: assert property (display_blank && $past(display_blank) |-> common_out_active == 4'h0)
    else $error("commons active while blanked");
  a_common_in_use: assert property (common_out_active != 4'h0 |-> $onehot(common_out_active)
    && (common_out_active & ~common_pin_lcd) == 4'h0) else $error("common phase illegal");
  a_static_one_com: assert property (static_bias && $past(static_bias) && lcd_enable && $past(lcd_enable)
    |-> common_pin_lcd == 4'h1 && !half_bias_sel) else $error("static duty pins or bias");
  a_off_to_port: assert property (!lcd_enable ##1 !lcd_enable |-> common_pin_lcd == 4'h0
    && segment_pin_lcd == 25'h0 && common_out_active == 4'h0) else $error("pins kept while off");
  c_third_frame: cover property (start_of_frame && common_pin_lcd == 4'h7);
  c_blanked: cover property (display_blank && lcd_enable);
  c_async_tick: cover property (prescaled_lcd_clock && seen && lcd_clock_source_sel);
endmodule // slcd_frame_timing_sva

bind slcd_frame_timing slcd_frame_timing_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .async_clk_tick, .lcd_enable, .display_blank, .lcd_clock_source_sel, .half_bias_sel,
  .static_bias, .prescaled_lcd_clock, .start_of_frame, .common_out_active, .common_pin_lcd, .segment_pin_lcd);

//--- testbench/slcd_glass_model.sv
// Purpose: Passive segment glass that records which commons it was driven on.
// Assumes: A common drives the glass only while its pin is in LCD function.
// Notes: Cleared by the bench before each frame measurement.
`timescale 1ns/1ns
module slcd_glass_model (
  input wire logic pclk,
  input wire logic clear,
  input wire logic [3:0] common_out_active,
  input wire logic [3:0] common_pin_lcd,
  output logic [3:0] commons_seen
);
  always @(posedge pclk) begin
    if (clear) commons_seen <= 4'h0;
    else commons_seen <= commons_seen | (common_out_active & common_pin_lcd);
  end
endmodule // slcd_glass_model

//--- testbench/tb_segment_lcd_frame_timing_config.sv
// Purpose: Self-checking bench for the segment LCD frame timing block.
// Assumes: APB slave answers with pready; async source pulses every third pclk.
// Notes: Read data and error are taken at the rising edge where ready is seen high.
`timescale 1ns/1ns
`include "slcd_regs.svh"
module tb_segment_lcd_frame_timing_config;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, async_clk_tick = 0, glass_clear = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, lcd_enable, bias_buffer_disable, internal_supply_disable, display_blank;
  logic lcd_clock_source_sel, half_bias_sel, static_bias, prescaled_lcd_clock, start_of_frame;
  logic [3:0] common_out_active, common_pin_lcd, commons_seen;
  logic [24:0] segment_pin_lcd;
  logic [1:0] div3 = 0;
  int failures = 0, comparisons = 0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    div3 <= (div3 == 2'd2) ? 2'd0 : div3 + 2'd1;
    async_clk_tick <= (div3 == 2'd2);
  end
  slcd_frame_timing DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .async_clk_tick, .lcd_enable, .bias_buffer_disable, .internal_supply_disable, .display_blank,
    .lcd_clock_source_sel, .half_bias_sel, .static_bias, .prescaled_lcd_clock, .start_of_frame,
    .common_out_active, .common_pin_lcd, .segment_pin_lcd);
  slcd_glass_model glass (.pclk, .clear(glass_clear), .common_out_active, .common_pin_lcd, .commons_seen);
  // ------------
  // Bus helpers
  // ------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 8'h00, q, e);
  endtask
  task automatic wait_sof(output int n);
    n = 0;
    do begin @(negedge pclk); n++; end while (start_of_frame !== 1'b1);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(`SLCD_ADDR_DUTY_BIAS, q); check("ctrl b reset", 32'h0, q);
    rd(`SLCD_ADDR_FRAME_RATE, q); check("frame reset", 32'h0, q);
    wr(`SLCD_ADDR_CTRL_A, 8'h67);
    repeat (2) @(negedge pclk);
    check("buffer off", 32'h1, {31'h0, bias_buffer_disable});
    check("supply off", 32'h1, {31'h0, internal_supply_disable});
    wr(`SLCD_ADDR_CTRL_A, 8'h00);
    repeat (2) @(negedge pclk);
    check("buffer on", 32'h0, {31'h0, bias_buffer_disable});
    check("supply on", 32'h0, {31'h0, internal_supply_disable});
    wr(`SLCD_ADDR_DUTY_BIAS, 8'hff); rd(`SLCD_ADDR_DUTY_BIAS, q); check("ctrl b bits", 32'hf7, q);
    wr(`SLCD_ADDR_FRAME_RATE, 8'hff); rd(`SLCD_ADDR_FRAME_RATE, q); check("frame bits", 32'h77, q);
    apb(1'b0, 12'h3a0, 8'h00, q, e);
    check("unmapped error", 32'h1, {31'h0, e});
  endtask
  task automatic t_pins;
    logic [2:0] c;
    int s;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      s = (i < 6) ? 13 + 2 * i : 18 + i;
      wr(`SLCD_ADDR_DUTY_BIAS, {c[2], c[2] ^ c[0], c[1:0], 1'b0, c});
      wr(`SLCD_ADDR_CTRL_A, 8'h82);
      repeat (2) @(negedge pclk);
      check("segments", (32'h1 << s) - 32'h1, {7'h0, segment_pin_lcd});
      check("commons", (32'h1 << (c[1:0] + 1)) - 32'h1, {28'h0, common_pin_lcd});
      check("static", {31'h0, c[1:0] == 2'b00}, {31'h0, static_bias});
      check("half bias", {31'h0, (c[2] ^ c[0]) && c[1:0] != 2'b00}, {31'h0, half_bias_sel});
      check("clock sel", {31'h0, c[2]}, {31'h0, lcd_clock_source_sel});
      wr(`SLCD_ADDR_CTRL_A, 8'h00);
      repeat (2) @(negedge pclk);
      check("ports back", 32'h0, {3'h0, common_pin_lcd, segment_pin_lcd});
    end
  endtask
  task automatic t_frame(input logic [2:0] ps, input logic [2:0] cd, input logic [1:0] duty, input logic as, input int exp);
    int n;
    logic [31:0] q;
    wr(`SLCD_ADDR_FRAME_RATE, {1'b0, ps, 1'b0, cd});
    wr(`SLCD_ADDR_DUTY_BIAS, {as, 1'b0, duty, 4'h7});
    wr(`SLCD_ADDR_CTRL_A, 8'h82);
    glass_clear <= 0;
    wait_sof(n);
    wait_sof(n);
    check("frame period", exp, n);
    check("glass commons", (32'h1 << (duty + 1)) - 32'h1, {28'h0, commons_seen});
    rd(`SLCD_ADDR_CTRL_A, q); check("flag set", 32'h1, {31'h0, q[4]});
    wr(`SLCD_ADDR_CTRL_A, 8'h92);
    rd(`SLCD_ADDR_CTRL_A, q); check("flag cleared", 32'h0, {31'h0, q[4]});
    wr(`SLCD_ADDR_CTRL_A, 8'h00);
    glass_clear <= 1;
  endtask
  task automatic t_blank;
    int n;
    wr(`SLCD_ADDR_FRAME_RATE, 8'h00);
    wr(`SLCD_ADDR_DUTY_BIAS, 8'h37);
    wr(`SLCD_ADDR_CTRL_A, 8'h82);
    wait_sof(n);
    wr(`SLCD_ADDR_CTRL_A, 8'h83);
    check("blank mid frame", 32'h0, {31'h0, display_blank});
    wait_sof(n);
    repeat (3) @(negedge pclk);
    check("blank in force", 32'h1, {31'h0, display_blank});
    check("commons grounded", 32'h0, {28'h0, common_out_active});
    wr(`SLCD_ADDR_CTRL_A, 8'h00);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_pins;
    t_frame(3'd0, 3'd0, 2'd3, 1'b0, 128);
    t_frame(3'd0, 3'd1, 2'd2, 1'b0, 192);
    t_frame(3'd1, 3'd0, 2'd0, 1'b0, 512);
    t_frame(3'd0, 3'd7, 2'd3, 1'b0, 1024);
    t_frame(3'd0, 3'd2, 2'd1, 1'b1, 1152);
    t_blank;
    end_of_test;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    end_of_test;
  end
endmodule // tb_segment_lcd_frame_timing_config
